// [logic/isp_pkg.sv]
// Package for the interrupt source prioritizer: register map, field layout,
// sense encodings, vector numbers and the peripheral source table.
// Assumes one 100 MHz system clock domain and an 8-bit register port.
`default_nettype none

package isp_pkg;

   // ----------------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------------
   localparam int NUM_LINES = 6;
   localparam int NUM_PERIPH = 45;
   localparam int NUM_PRIO_REGS = 10;
   localparam int PRIO_W = 3;

   // ----------------------------------------------------------------------
   // Register offsets on the 8-bit register port
   // ----------------------------------------------------------------------
   localparam logic [7:0] ADDR_SYS_CTRL = 8'h00;
   localparam logic [7:0] ADDR_SENSE_LO = 8'h01;
   localparam logic [7:0] ADDR_SENSE_HI = 8'h02;
   localparam logic [7:0] ADDR_ENABLE = 8'h03;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_PRIO_BASE = 8'h10;
   localparam logic [7:0] ADDR_PRIO_LAST = 8'h19;

   // ----------------------------------------------------------------------
   // Field layout and reset values
   // ----------------------------------------------------------------------
   localparam int SYS_EDGE_BIT = 0;
   localparam int SYS_MODE_BIT = 1;
   localparam logic [7:0] SYS_CTRL_MASK = 8'h03;
   localparam logic [7:0] SYS_CTRL_RESET = 8'h00;
   localparam logic [7:0] SENSE_RESET = 8'h00;
   localparam logic [7:0] ENABLE_MASK = 8'h3F;
   localparam logic [7:0] STATUS_MASK = 8'h3F;
   localparam logic [7:0] PRIO_REG_MASK = 8'h77;
   localparam logic [7:0] PRIO_REG_RESET = 8'h77;
   localparam int PRIO_HI_LSB = 4;
   localparam int PRIO_LO_LSB = 0;
   localparam logic [7:0] READ_IDLE = 8'h00;

   // ----------------------------------------------------------------------
   // Sense encodings
   // ----------------------------------------------------------------------
   localparam logic [1:0] SENSE_LOW = 2'h0;
   localparam logic [1:0] SENSE_FALL = 2'h1;
   localparam logic [1:0] SENSE_RISE = 2'h2;
   localparam logic [1:0] SENSE_BOTH = 2'h3;

   // ----------------------------------------------------------------------
   // Vectors and levels
   // ----------------------------------------------------------------------
   localparam logic [7:0] VEC_NMI = 8'h07;
   localparam logic [7:0] VEC_LINE0 = 8'h10;
   localparam logic [2:0] NMI_LEVEL = 3'h7;
   localparam logic [2:0] DEFAULT_LEVEL = 3'h0;

   // Priority field index: register index times two, plus one for bits 2-0
   localparam logic [4:0] LINE_FIELD [NUM_LINES] = '{5'h00, 5'h01, 5'h02, 5'h02, 5'h03, 5'h03};

   // Peripheral sources in ascending vector order; the index is the port bit
   localparam logic [7:0] PERIPH_VEC [NUM_PERIPH] = '{
      8'h19, 8'h1C, 8'h1D,
      8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h28, 8'h29, 8'h2A, 8'h2B,
      8'h2C, 8'h2D, 8'h2E, 8'h2F, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34,
      8'h38, 8'h39, 8'h3A, 8'h3B, 8'h3C, 8'h3D, 8'h3E, 8'h3F,
      8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'h57,
      8'h58, 8'h59, 8'h5A, 8'h5B, 8'h68, 8'h69, 8'h6A, 8'h6B};
   localparam logic [4:0] PERIPH_FIELD [NUM_PERIPH] = '{
      5'h04, 5'h07, 5'h07,
      5'h08, 5'h08, 5'h08, 5'h08, 5'h08, 5'h09, 5'h09, 5'h09, 5'h09,
      5'h0A, 5'h0A, 5'h0A, 5'h0A, 5'h0B, 5'h0B, 5'h0B, 5'h0B, 5'h0B,
      5'h0C, 5'h0C, 5'h0C, 5'h0C, 5'h0D, 5'h0D, 5'h0D, 5'h0D,
      5'h0F, 5'h0F, 5'h0F, 5'h0F, 5'h10, 5'h10, 5'h10, 5'h10,
      5'h11, 5'h11, 5'h11, 5'h11, 5'h12, 5'h12, 5'h12, 5'h12};

   // ----------------------------------------------------------------------
   // Carrier to the processor core
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic valid;
      logic nmi;
      logic [7:0] vector;
      logic [15:0] table_addr;
      logic [2:0] level;
   } isp_grant_t;

   // Table entry address: vector number times four
   function automatic logic [15:0] vec_addr(input logic [7:0] vec);
      vec_addr = {6'h00, vec, 2'h0};
   endfunction

endpackage

`default_nettype wire

// [logic/isp_pin_sense.sv]
// One external request pin: two-stage synchroniser, previous-sample register
// and the sense decoder. Assumes the pin is asynchronous to sys_clk.
`default_nettype none

module isp_pin_sense (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic pin,
   input wire logic [1:0] sense,
   output logic hit,
   output logic pin_high
);

   logic meta_reg;
   logic sync_reg;
   logic prev_reg;

   // ----------------------------------------------------------------------
   // Synchroniser; idle high so the release of reset makes no false edge
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         meta_reg <= 1'b1;
         sync_reg <= 1'b1;
         prev_reg <= 1'b1;
      end else begin
         meta_reg <= pin;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   // ----------------------------------------------------------------------
   // Sense decode
   // ----------------------------------------------------------------------
   always_comb begin
      case (sense)
         isp_pkg::SENSE_LOW: hit = ~sync_reg;
         isp_pkg::SENSE_FALL: hit = prev_reg & ~sync_reg;
         isp_pkg::SENSE_RISE: hit = ~prev_reg & sync_reg;
         isp_pkg::SENSE_BOTH: hit = prev_reg ^ sync_reg;
         default: hit = 1'b0;
      endcase
   end

   assign pin_high = sync_reg;

endmodule

`default_nettype wire

// [logic/isp_interrupt_prioritizer.sv]
// Interrupt source prioritizer: external pin detection, request flags,
// programmable priority ranking and the vector offered to the processor.
// Assumes the core and the peripherals run on sys_clk; pins are asynchronous.
//
// Behaviour
// - Seven external sources, non-maskable plus six lines, each can wake standby.
// - Non-maskable request ranks highest and ignores mode and processor mask.
// - A control bit picks rising or falling edge for the non-maskable pin.
// - Each line selects low level, falling, rising or both edges.
// - A line whose enable bit is clear is never offered to the core.
// - Each line has a status flag that software can clear to zero.
// - Line detection ignores whether the pin is set as input or output.
// - A peripheral requests only while its flag and enable are both one.
// - Lines and peripheral modules each have a programmable priority field.
// - By default a lower vector number ranks above a higher one.
// - Equal programmed levels are resolved by default vector order.
// - Sources inside one module rank by fixed vector order only.
// - Non-maskable is vector 7; lines are vectors 16 to 21.
// - Line 0 and 1 use register A fields; 2-3 and 4-5 share register B.
// - Peripheral sources use their listed vectors and priority fields.
// - Vectors 22, 23 and 111 carry no source.
// - Each table entry gives only the low 16 bits of the routine address.
// - Sense field codes 00 low, 01 falling, 10 rising, 11 both; reset zero.
// - Flag sets on its sense event, clears by read-one-write-zero or handling.
// - In level mode a request is taken only above the processor mask level.
//
// Strobed register access and the address map were decided locally.
`default_nettype none

module isp_interrupt_prioritizer (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic nmi_pin,
   input wire logic [5:0] irq_pin_n,
   input wire logic [44:0] periph_flag,
   input wire logic [44:0] periph_enable,
   input wire logic cpu_i_bit,
   input wire logic [2:0] cpu_mask_level,
   input wire logic cpu_ack,
   input wire logic [7:0] cpu_ack_vector,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output isp_pkg::isp_grant_t grant,
   output logic standby_wake
);

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   logic [7:0] system_control_reg;
   logic [7:0] sense_lo_reg;
   logic [7:0] sense_hi_reg;
   logic [5:0] request_enable_reg;
   logic [5:0] request_status_reg;
   logic [5:0] request_status_next;
   logic [5:0] read_armed_reg;

   logic nmi_pending_reg;
   logic [7:0] priority_level_reg [isp_pkg::NUM_PRIO_REGS];

   logic [7:0] reg_rdata_reg;
   isp_pkg::isp_grant_t grant_reg;
   isp_pkg::isp_grant_t grant_next;
   logic standby_wake_reg;

   logic [11:0] request_sense_control;
   logic nonmaskable_edge_select;
   logic level_mode;
   logic [1:0] nmi_sense;

   logic nmi_hit;
   logic [5:0] line_hit;
   logic [5:0] line_high;
   logic [5:0] line_forward;

   logic [5:0] sw_clear;
   logic [5:0] ack_clear;
   logic [44:0] periph_req;

   logic [7:0] read_value;
   logic status_write;

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   // Priority level of a field; in default mode every level is equal so only
   // vector order ranks
   function automatic logic [2:0] field_level(input logic [7:0] r, input logic lo_half,
                                              input logic prog);
      logic [2:0] lvl;
      lvl = lo_half ? r[isp_pkg::PRIO_LO_LSB +: isp_pkg::PRIO_W]
                    : r[isp_pkg::PRIO_HI_LSB +: isp_pkg::PRIO_W];

      field_level = prog ? lvl : isp_pkg::DEFAULT_LEVEL;
   endfunction

   function automatic logic [1:0] line_sense(input logic [11:0] ctl, input int n);
      line_sense = ctl[2*n +: 2];
   endfunction

   // ----------------------------------------------------------------------
   // Control decode
   // ----------------------------------------------------------------------
   assign request_sense_control = {sense_hi_reg[3:0], sense_lo_reg};
   assign nonmaskable_edge_select = system_control_reg[isp_pkg::SYS_EDGE_BIT];
   assign level_mode = system_control_reg[isp_pkg::SYS_MODE_BIT];

   // Only the two edge codes make sense for this pin
   assign nmi_sense = nonmaskable_edge_select ? isp_pkg::SENSE_RISE
                                              : isp_pkg::SENSE_FALL;

   assign status_write = reg_wr && (reg_addr == isp_pkg::ADDR_STATUS);

   // ----------------------------------------------------------------------
   // Pin detection
   // ----------------------------------------------------------------------
   // The pads feed the detectors whatever their direction setting, so
   // driving the pin as an output still raises requests
   isp_pin_sense u_nmi_sense (
      .sys_clk(sys_clk),
      .srst(srst),
      .pin(nmi_pin),
      .sense(nmi_sense),
      .hit(nmi_hit),
      .pin_high()
   );

   for (genvar n = 0; n < isp_pkg::NUM_LINES; n++) begin : g_line
      isp_pin_sense u_line_sense (
         .sys_clk(sys_clk),
         .srst(srst),
         .pin(irq_pin_n[n]),
         .sense(line_sense(request_sense_control, n)),
         .hit(line_hit[n]),
         .pin_high(line_high[n])
      );
   end

   // ----------------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         system_control_reg <= isp_pkg::SYS_CTRL_RESET;
         sense_lo_reg <= isp_pkg::SENSE_RESET;
         sense_hi_reg <= isp_pkg::SENSE_RESET;
         request_enable_reg <= '0;
      end else if (reg_wr) begin
         case (reg_addr)
            isp_pkg::ADDR_SYS_CTRL: system_control_reg <= reg_wdata & isp_pkg::SYS_CTRL_MASK;
            isp_pkg::ADDR_SENSE_LO: sense_lo_reg <= reg_wdata;
            isp_pkg::ADDR_SENSE_HI: sense_hi_reg <= {4'h0, reg_wdata[3:0]};
            isp_pkg::ADDR_ENABLE: request_enable_reg <= reg_wdata[5:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         for (int i = 0; i < isp_pkg::NUM_PRIO_REGS; i++) begin
            priority_level_reg[i] <= isp_pkg::PRIO_REG_RESET;
         end
      end else if (reg_wr && reg_addr >= isp_pkg::ADDR_PRIO_BASE &&
                   reg_addr <= isp_pkg::ADDR_PRIO_LAST) begin
         priority_level_reg[4'(reg_addr - isp_pkg::ADDR_PRIO_BASE)] <=
            reg_wdata & isp_pkg::PRIO_REG_MASK;
      end
   end

   // ----------------------------------------------------------------------
   // Line status flags
   // ----------------------------------------------------------------------
   // A zero write clears only flags seen as one by an earlier read, so a
   // request arriving between the read and the write survives
   always_comb begin
      for (int n = 0; n < isp_pkg::NUM_LINES; n++) begin
         sw_clear[n] = status_write && read_armed_reg[n] && !reg_wdata[n];

         // Level sense clears on handling only once the pin is back high
         ack_clear[n] = cpu_ack && (cpu_ack_vector == isp_pkg::VEC_LINE0 + 8'(n)) &&
                        (line_sense(request_sense_control, n) != isp_pkg::SENSE_LOW ||
                         line_high[n]);
      end

      // Set wins over any clear in the same cycle
      request_status_next = (request_status_reg & ~(sw_clear | ack_clear)) |
                            line_hit;
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         request_status_reg <= '0;
      end else begin
         request_status_reg <= request_status_next;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         read_armed_reg <= '0;
      end else if (reg_rd && reg_addr == isp_pkg::ADDR_STATUS) begin
         read_armed_reg <= request_status_reg;
      end else if (status_write) begin
         read_armed_reg <= '0;
      end
   end

   // Non-maskable request stays pending until its own vector is handled
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         nmi_pending_reg <= 1'b0;
      end else if (nmi_hit) begin
         nmi_pending_reg <= 1'b1;
      end else if (cpu_ack && cpu_ack_vector == isp_pkg::VEC_NMI) begin
         nmi_pending_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Request qualification
   // ----------------------------------------------------------------------
   assign line_forward = request_status_reg & request_enable_reg;
   assign periph_req = periph_flag & periph_enable;

   // ----------------------------------------------------------------------
   // Ranking
   // ----------------------------------------------------------------------
   // Candidates are scanned in ascending vector order and only a strictly
   // higher level displaces the holder, so ties fall to the lower vector
   always_comb begin
      logic [2:0] lvl;
      logic [4:0] fld;
      lvl = isp_pkg::DEFAULT_LEVEL;
      fld = '0;
      grant_next = '0;

      for (int n = 0; n < isp_pkg::NUM_LINES; n++) begin
         fld = isp_pkg::LINE_FIELD[n];
         lvl = field_level(priority_level_reg[fld[4:1]], fld[0], level_mode);
         if (line_forward[n] && (!grant_next.valid || lvl > grant_next.level)) begin
            grant_next.valid = 1'b1;
            grant_next.vector = isp_pkg::VEC_LINE0 + 8'(n);
            grant_next.level = lvl;
         end
      end
      for (int p = 0; p < isp_pkg::NUM_PERIPH; p++) begin
         fld = isp_pkg::PERIPH_FIELD[p];
         lvl = field_level(priority_level_reg[fld[4:1]], fld[0], level_mode);
         if (periph_req[p] && (!grant_next.valid || lvl > grant_next.level)) begin
            grant_next.valid = 1'b1;
            grant_next.vector = isp_pkg::PERIPH_VEC[p];
            grant_next.level = lvl;
         end
      end

      // Maskable winner is offered only if the processor mask lets it in
      if (level_mode) begin
         grant_next.valid = grant_next.valid && (grant_next.level > cpu_mask_level);
      end else begin
         grant_next.valid = grant_next.valid && !cpu_i_bit;
      end

      if (nmi_pending_reg) begin
         grant_next.valid = 1'b1;
         grant_next.nmi = 1'b1;
         grant_next.vector = isp_pkg::VEC_NMI;
         grant_next.level = isp_pkg::NMI_LEVEL;
      end

      if (!grant_next.valid) begin
         grant_next.vector = '0;
         grant_next.level = '0;
      end

      grant_next.table_addr = isp_pkg::vec_addr(grant_next.vector);
   end

   // An offer in flight is dropped in the cycle its vector is acknowledged,
   // so the core never sees a stale repeat of a source it just took
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         grant_reg <= '0;
      end else if (cpu_ack && grant_reg.valid && cpu_ack_vector == grant_reg.vector) begin
         grant_reg <= '0;
      end else begin
         grant_reg <= grant_next;
      end
   end

   // ----------------------------------------------------------------------
   // Standby wake
   // ----------------------------------------------------------------------
   // Enabled line requests and the non-maskable pin wake the device; the
   // pin path needs the clock running, so standby must keep sys_clk alive
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         standby_wake_reg <= 1'b0;
      end else begin
         standby_wake_reg <= nmi_pending_reg || (|line_forward);
      end
   end

   // ----------------------------------------------------------------------
   // Register reads
   // ----------------------------------------------------------------------
   always_comb begin
      read_value = isp_pkg::READ_IDLE;
      case (reg_addr)
         isp_pkg::ADDR_SYS_CTRL: read_value = system_control_reg;
         isp_pkg::ADDR_SENSE_LO: read_value = sense_lo_reg;
         isp_pkg::ADDR_SENSE_HI: read_value = sense_hi_reg;
         isp_pkg::ADDR_ENABLE: read_value = {2'h0, request_enable_reg};
         isp_pkg::ADDR_STATUS: read_value = {2'h0, request_status_reg};
         default: begin
            if (reg_addr >= isp_pkg::ADDR_PRIO_BASE && reg_addr <= isp_pkg::ADDR_PRIO_LAST) begin
               read_value = priority_level_reg[4'(reg_addr - isp_pkg::ADDR_PRIO_BASE)];
            end
         end
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         reg_rdata_reg <= isp_pkg::READ_IDLE;
      end else if (reg_rd) begin
         reg_rdata_reg <= read_value;
      end else begin
         reg_rdata_reg <= isp_pkg::READ_IDLE;
      end
   end

   assign reg_rdata = reg_rdata_reg;
   assign grant = grant_reg;
   assign standby_wake = standby_wake_reg;

endmodule

`default_nettype wire

// [bench/isp_prioritizer_sva.sv]
// Port checker for the prioritizer: grant encoding, masking and read port.
// Assumes it is bound to isp_interrupt_prioritizer in the bench top file.
`default_nettype none
module isp_prioritizer_sva (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic cpu_i_bit,
   input wire logic [2:0] cpu_mask_level,
   input wire logic cpu_ack,
   input wire logic [7:0] cpu_ack_vector,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire isp_pkg::isp_grant_t grant
);
   timeunit 1ns;
   timeprecision 1ps;
   // Mode bit shadowed from writes so masking is judged from the ports
   logic mode_reg;
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         mode_reg <= 1'b0;
      end else if (reg_wr && reg_addr == isp_pkg::ADDR_SYS_CTRL) begin
         mode_reg <= reg_wdata[isp_pkg::SYS_MODE_BIT];
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   sequence s_take;
      cpu_ack && grant.valid && cpu_ack_vector == grant.vector;
   endsequence
   sequence s_drop;
      !grant.valid;
   endsequence
   property p_ack_clears;
      s_take |=> s_drop;
   endproperty
   a_ack_clears: assert property (p_ack_clears)
      else $error("grant kept after its ack");
   property p_addr;
      grant.valid |-> grant.table_addr == {6'h00, grant.vector, 2'h0};
   endproperty
   a_addr: assert property (p_addr) else $error("table address wrong");
   property p_idle;
      !grant.valid |-> grant.vector == 8'h00 && grant.level == 3'h0 && grant.table_addr == 16'h0;
   endproperty
   a_idle: assert property (p_idle) else $error("idle grant not zero");
   property p_nmi;
      grant.nmi |-> grant.valid && grant.vector == isp_pkg::VEC_NMI && grant.level == 3'h7;
   endproperty
   a_nmi: assert property (p_nmi) else $error("nonmaskable grant wrong");
   property p_reserved;
      grant.valid |-> !(grant.vector inside {8'h16, 8'h17, 8'h6F});
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved vector");
   property p_mode0;
      grant.valid && !grant.nmi && !$past(mode_reg) |-> !$past(cpu_i_bit) && grant.level == 3'h0;
   endproperty
   a_mode0: assert property (p_mode0) else $error("masked grant in mode 0");
   property p_mode1;
      grant.valid && !grant.nmi && $past(mode_reg) |-> grant.level > $past(cpu_mask_level);
   endproperty
   a_mode1: assert property (p_mode1) else $error("grant not above mask");
   property p_rdata;
      !$past(reg_rd) |-> reg_rdata == 8'h00;
   endproperty
   a_rdata: assert property (p_rdata) else $error("read data outside slot");
endmodule
`default_nettype wire

// [bench/isp_core_model.sv]
// Processor core model: takes each grant after a set delay.
// Assumes one clock shared with the prioritizer.
`default_nettype none
module isp_core_model (
   input wire logic sys_clk,
   input wire logic srst,
   input wire isp_pkg::isp_grant_t grant,
   input wire logic auto_ack,
   input wire logic [3:0] ack_delay,
   output logic cpu_ack,
   output logic [7:0] cpu_ack_vector
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] wait_reg;
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         wait_reg <= 4'h0;
         cpu_ack <= 1'b0;
         cpu_ack_vector <= 8'hFF;
      end else if (!cpu_ack && auto_ack && grant.valid && wait_reg == ack_delay) begin
         cpu_ack <= 1'b1;
         cpu_ack_vector <= grant.vector;
      end else begin
         // Vector toggles off the ack so a stale value never matches
         cpu_ack <= 1'b0;
         cpu_ack_vector <= ~cpu_ack_vector;
         wait_reg <= (grant.valid && !cpu_ack) ? wait_reg + 4'h1 : 4'h0;
      end
   end
endmodule
`default_nettype wire

// [bench/isp_interrupt_prioritizer_bench.sv]
// Bench top: drives pins, peripheral flags and registers, judges grants.
// Assumes the core model answers grants; no other agent drives inputs.
`default_nettype none
module isp_interrupt_prioritizer_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, srst, nmi_pin, cpu_i_bit, reg_wr, reg_rd, auto_ack, cpu_ack, standby_wake;
   logic [5:0] irq_pin_n;
   logic [44:0] periph_flag, periph_enable;
   logic [2:0] cpu_mask_level;
   logic [7:0] cpu_ack_vector, reg_addr, reg_wdata, reg_rdata, rd_data;
   logic [3:0] ack_delay;
   isp_pkg::isp_grant_t grant;
   int n_errors = 0, comparisons = 0;
   isp_interrupt_prioritizer u_isp_interrupt_prioritizer (.sys_clk, .srst, .nmi_pin,
      .irq_pin_n, .periph_flag, .periph_enable, .cpu_i_bit, .cpu_mask_level, .cpu_ack,
      .cpu_ack_vector, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .grant,
      .standby_wake);
   isp_core_model u_isp_core_model (.sys_clk, .srst, .grant, .auto_ack, .ack_delay,
      .cpu_ack, .cpu_ack_vector);
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic check(input string what, input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wrap_up();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(posedge sys_clk);
      {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk);
      {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 rd_data = reg_rdata;
   endtask
   task automatic wait_grant(input logic [7:0] vec, input logic [2:0] lvl);
      int i;
      for (i = 0; i < 40 && grant.valid !== 1'b1; i++) @(posedge sys_clk) #1;
      if (i == 40) begin
         n_errors++;
         wrap_up();
      end
      check("vector", grant.vector, vec);
      check("level", grant.level, lvl);
      check("table_addr", grant.table_addr, {vec, 2'b00});
   endtask
   task automatic no_grant();
      repeat (12) begin
         @(posedge sys_clk) #1;
         check("valid", grant.valid, 1'b0);
      end
   endtask
   task automatic quiet();
      @(posedge sys_clk);
      {periph_flag, periph_enable} <= '0;
      repeat (8) @(posedge sys_clk);
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      wr(8'h05, 8'hFF);
      for (int k = 0; k < 26; k++) begin
         rd(8'(k));
         check("reg", rd_data, (k >= 16) ? 8'h77 : 8'h00);
      end
   endtask
   task automatic t_periph();
      {periph_flag, periph_enable} <= {45'h3, 45'h2};
      wait_grant(8'h1C, 3'h0);
      quiet();
      {periph_flag, periph_enable} <= {45'h3, 45'h3};
      wait_grant(8'h19, 3'h0);
      @(posedge sys_clk);
      cpu_i_bit <= 1'b1;
      no_grant();
   endtask
   task automatic t_levels();
      wr(isp_pkg::ADDR_SYS_CTRL, 8'h02);
      {cpu_mask_level, ack_delay} <= {3'h7, 4'h9};
      {periph_flag, periph_enable} <= {45'h3, 45'h3};
      no_grant();
      cpu_mask_level <= 3'h6;
      wait_grant(8'h19, 3'h7);
      quiet();
      wr(8'h12, 8'h17);
      wr(8'h13, 8'h73);
      {cpu_mask_level, periph_flag, periph_enable} <= {3'h0, 45'h7, 45'h7};
      wait_grant(8'h1C, 3'h3);
      quiet();
      wr(8'h13, 8'h71);
      {periph_flag, periph_enable} <= {45'h7, 45'h7};
      wait_grant(8'h19, 3'h1);
      quiet();
   endtask
   task automatic t_lines();
      {cpu_i_bit, ack_delay} <= {1'b0, 4'h1};
      wr(isp_pkg::ADDR_SYS_CTRL, 8'h00);
      for (int c = 0; c < 4; c++) begin
         wr(isp_pkg::ADDR_SENSE_LO, 8'(c));
         irq_pin_n[0] <= 1'b0;
         repeat (6) @(posedge sys_clk);
         rd(isp_pkg::ADDR_STATUS);
         check("flag_fall", rd_data[0], c != 2);
         irq_pin_n[0] <= 1'b1;
         no_grant();
         rd(isp_pkg::ADDR_STATUS);
         check("flag_rise", rd_data[0], 1'b1);
         wr(isp_pkg::ADDR_STATUS, 8'h00);
         rd(isp_pkg::ADDR_STATUS);
         check("flag_clear", rd_data, 8'h00);
      end
      wr(isp_pkg::ADDR_SENSE_LO, {6'h00, isp_pkg::SENSE_FALL});
      wr(isp_pkg::ADDR_ENABLE, 8'h01);
      {auto_ack, irq_pin_n[0]} <= 2'b00;
      wait_grant(8'h10, 3'h0);
      check("wake", standby_wake, 1'b1);
      {auto_ack, irq_pin_n[0]} <= 2'b11;
      quiet();
      no_grant();
      rd(isp_pkg::ADDR_STATUS);
      check("flag_handled", rd_data, 8'h00);
   endtask
   task automatic t_nmi();
      wr(isp_pkg::ADDR_SYS_CTRL, 8'h01);
      {cpu_i_bit, nmi_pin, periph_flag, periph_enable} <= {2'b10, 45'h1, 45'h1};
      repeat (6) @(posedge sys_clk);
      nmi_pin <= 1'b1;
      wait_grant(isp_pkg::VEC_NMI, 3'h7);
      check("nmi", grant.nmi, 1'b1);
      wr(isp_pkg::ADDR_SYS_CTRL, 8'h00);
      no_grant();
      nmi_pin <= 1'b0;
      wait_grant(isp_pkg::VEC_NMI, 3'h7);
   endtask
   initial begin
      {srst, nmi_pin, irq_pin_n, cpu_i_bit, cpu_mask_level} = {2'b11, 6'h3F, 4'h0};
      {periph_flag, periph_enable, reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
      {auto_ack, ack_delay} = {1'b1, 4'h0};
      repeat (3) @(posedge sys_clk);
      srst <= 1'b0;
      t_reset();
      t_periph();
      t_levels();
      t_lines();
      t_nmi();
      wrap_up();
   end
endmodule
bind isp_interrupt_prioritizer isp_prioritizer_sva u_isp_prioritizer_sva (.sys_clk, .srst,
   .cpu_i_bit, .cpu_mask_level, .cpu_ack, .cpu_ack_vector, .reg_addr, .reg_wdata, .reg_wr,
   .reg_rd, .reg_rdata, .grant);
`default_nettype wire
